// ---- inc/quad_consts.svh ----
/*
  Register offsets, field layout, reset values and timing counts of the
  quadrature decoder. Assumes a 12-bit APB byte address.
*/
`ifndef QUAD_CONSTS_SVH
`define QUAD_CONSTS_SVH
`define OFS_START        12'h000
`define OFS_STOP         12'h004
`define OFS_SNAP_BOTH    12'h008
`define OFS_SNAP_MOTION  12'h00C
`define OFS_SNAP_DOUBLE  12'h010
`define OFS_EV_SAMPLE    12'h100
`define OFS_EV_REPORT    12'h104
`define OFS_EV_OVF       12'h108
`define OFS_EV_DOUBLE    12'h10C
`define OFS_EV_HALT      12'h110
`define OFS_LINKS        12'h200
`define OFS_IRQ_SET      12'h304
`define OFS_IRQ_CLR      12'h308
`define OFS_ENABLE       12'h500
`define OFS_POLARITY     12'h504
`define OFS_INTERVAL     12'h508
`define OFS_SAMPLE       12'h50C
`define OFS_REPORT_CNT   12'h510
`define OFS_ACC          12'h514
`define OFS_ACC_SNAP     12'h518
`define OFS_SEL_LED      12'h51C
`define OFS_SEL_A        12'h520
`define OFS_SEL_B        12'h524
`define OFS_DEBOUNCE     12'h528
`define OFS_LEAD         12'h540
`define OFS_DBL          12'h544
`define OFS_DBL_SNAP     12'h548
// Pin select: pin number in [4:0], bit 31 set means disconnected
`define SEL_OFF_BIT      31
`define SEL_RESET        32'hFFFFFFFF
// Shortcut bit positions
`define LNK_REP_BOTH     0
`define LNK_SMP_STOP     1
`define LNK_REP_MOTION   2
`define LNK_REP_STOP     3
`define LNK_DBL_DOUBLE   4
`define LNK_DBL_STOP     5
`define LNK_SMP_START    6
// Accumulator limits
`define ACC_MAX          32'sd1023
`define ACC_MIN          -32'sd1024
`define DBL_MAX          32'd15
// Timing
`define CLK_MHZ          250
`define SAMPLE_BASE_US   128
`define MAX_INTERVAL     4'hA
`define DBF_TICK_NS      1000
`define CLK_PERIOD_NS    4
`define DBF_TICK_CYC     (`DBF_TICK_NS / `CLK_PERIOD_NS)
`endif

// ---- inc/quad_pkg.sv ----
/*
  Types shared by the quadrature decoder modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package quad_pkg;
  typedef enum logic {ST_IDLE, ST_RUN} run_e;
  typedef logic [5:0] sel_t; // {disconnected, pin[4:0]}
endpackage

// ---- inc/route_if.sv ----
/*
  Carrier between the decoder core and its pin router.
  Assumes quad_pkg is compiled first.
*/
`timescale 1ns/1ps
interface route_if;
  import quad_pkg::*;
  logic enable;
  sel_t sel_a;
  sel_t sel_b;
  sel_t sel_led;
  logic led_level;
  logic phase_a;
  logic phase_b;
  modport core (output enable, sel_a, sel_b, sel_led, led_level,
                input phase_a, phase_b);
  modport router (input enable, sel_a, sel_b, sel_led, led_level,
                  output phase_a, phase_b);
endinterface

// ---- rtl/pin_router.sv ----
/*
  Pin router: synchronises all pads, lends the selected pins to the
  decoder while it is enabled, and otherwise passes the port's own
  output value and direction through. Assumes 32 pads.
*/
`timescale 1ns/1ps
module pin_router
  import quad_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Decoder side
  route_if.router          rt,
  // Pads and port settings
  input  wire logic [31:0] pad_in,
  input  wire logic [31:0] gpio_out_val,
  input  wire logic [31:0] gpio_out_en,
  output logic      [31:0] pad_out,
  output logic      [31:0] pad_oe,
  output logic      [31:0] gpio_read
);

  logic [31:0] sync1;
  logic [31:0] sync2;
  logic [31:0] sync3;
  logic [31:0] stable;

  // One-hot pin mask, empty when disabled or disconnected
  function automatic logic [31:0] pin_mask(input sel_t s, input logic en);
    pin_mask = (en && !s[5]) ? (32'h00000001 << s[4:0]) : 32'h00000000;
  endfunction

  wire [31:0] a_m    = pin_mask(rt.sel_a, rt.enable);   // R4 R5 R6
  wire [31:0] b_m    = pin_mask(rt.sel_b, rt.enable);   // R4 R5 R6
  wire [31:0] led_m  = pin_mask(rt.sel_led, rt.enable); // R4 R5 R6
  wire [31:0] own_m  = a_m | b_m | led_m;               // R2
  wire [31:0] agree  = ~(sync2 ^ sync3);

  // Three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1  <= 32'h00000000;
      sync2  <= 32'h00000000;
      sync3  <= 32'h00000000;
      stable <= 32'h00000000;
    end else begin
      sync1  <= pad_in;
      sync2  <= sync1;
      sync3  <= sync2;
      stable <= (sync3 & agree) | (stable & ~agree);
    end
  end

  // The indicator pin ignores the port's value; phase pins are forced to input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out   <= 32'h00000000;
      pad_oe    <= 32'h00000000;
      gpio_read <= 32'h00000000;
    end else begin
      pad_out   <= (gpio_out_val & ~led_m) | (led_m & {32{rt.led_level}}); // R3 R7
      pad_oe    <= (gpio_out_en & ~own_m) | led_m; // R1 R7
      gpio_read <= stable; // R3
    end
  end

  assign rt.phase_a = |(stable & a_m); // R1
  assign rt.phase_b = |(stable & b_m); // R1

endmodule

// ---- rtl/quadrature_decoder.sv ----
/*
  Quadrature decoder core with APB register file: sampling, decoding,
  accumulators, events, shortcuts, debounce and indicator timing.
  Assumes a 250 MHz pclk, an APB master and 32 pads behind pin_router.
*/
`timescale 1ns/1ps
`include "quad_consts.svh"

// Functional notes
// (R1) Three encoder signals: phase A, B, indicator
// (R2) Own selected pins only while enabled
// (R3) Owned pins ignore writes, reads stay live
// (R4) Each signal routed by its select register
// (R5) Disconnected select attaches no pin
// (R6) Selects act only while enabled
// (R7) Disabled pins behave as ordinary port pins
// (R8) Software sets decoder pins as inputs first
// (R9) Software never double-assigns a driving pin
// (R10) Start task begins periodic sampling
// (R11) Stop task halts, then halted flag
// (R12) Sample-ready flag on each new sample
// (R13) Motion snapshot loads on its tasks only
// (R14) Double snapshot loads on its tasks only
// (R15) Report count sets samples per report
// (R16) Overflow flag when accumulator would overflow
// (R17) Report-ready if motion, double-ready if doubles
// (R18) Shortcuts link events to tasks
// (R19) Lead time register, debounce enable register
// (R20) Decode pair change to 0, +1, -1, 2
// (R21) Overflowing samples discarded, later ones kept
// (R22) Indicator on lead time before each sample
// (R23) Debounce: accept only unanimous 1 MHz samples
// (R24) Tasks pulse on write 1; flags cleared by 0
module quadrature_decoder
  import quad_pkg::*;
#(
  parameter int SAMPLE_BASE_CYC = `SAMPLE_BASE_US * `CLK_MHZ
)(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pads and port settings
  input  wire logic [31:0] pad_in,
  input  wire logic [31:0] gpio_out_val,
  input  wire logic [31:0] gpio_out_en,
  output logic      [31:0] pad_out,
  output logic      [31:0] pad_oe,
  output logic      [31:0] gpio_read
);

  route_if rt ();

  run_e        state;
  run_e        next_state;
  logic        en;
  logic        pol;
  logic [3:0]  interval;
  logic [3:0]  rep_cnt_cfg;
  logic        dbf;
  logic [8:0]  lead;
  logic [6:0]  links;
  logic [4:0]  irq_mask;
  sel_t        sel_a;
  sel_t        sel_b;
  sel_t        sel_led;
  logic [31:0] sample;
  logic [31:0] acc;
  logic [31:0] acc_snap;
  logic [31:0] dbl;
  logic [31:0] dbl_snap;
  logic [4:0]  flags; // sample, report, ovf, double, halt
  logic [4:0]  rep_seen;
  logic [31:0] rem;
  logic [7:0]  tick_cnt;
  logic [1:0]  prev_pair;
  logic [1:0]  last_pair;
  logic [1:0]  filt_pair;
  logic [1:0]  agree;
  logic        led_level;
  logic [6:0]  link_q; // registered shortcut tasks
  logic [31:0] rd_word;
  logic        rd_ok;

  // Sample period in cycles, doubling per interval step up to step 10
  function automatic logic [31:0] period_cyc(input logic [3:0] v);
    logic [3:0] s;
    s = (v > `MAX_INTERVAL) ? `MAX_INTERVAL : v;
    period_cyc = 32'(SAMPLE_BASE_CYC) << s;
  endfunction

  // Gray position of a phase pair, A in bit 1
  function automatic logic [1:0] gray_pos(input logic [1:0] p);
    gray_pos = {p[1], p[1] ^ p[0]};
  endfunction

  // Packs a select word into its disconnect bit 31 and pin number [4:0]
  function automatic sel_t to_sel(input logic [31:0] w);
    to_sel = {w[`SEL_OFF_BIT], w[4:0]};
  endfunction

  // APB strobes; the slave never inserts wait states
  wire setup   = psel & ~penable;
  wire wr      = psel & penable & pwrite;
  wire w1      = pwdata[0];
  wire wr_start  = wr && paddr == `OFS_START && w1;         // R24
  wire wr_stop   = wr && paddr == `OFS_STOP && w1;          // R24
  wire wr_both   = wr && paddr == `OFS_SNAP_BOTH && w1;     // R24
  wire wr_motion = wr && paddr == `OFS_SNAP_MOTION && w1;   // R24
  wire wr_double = wr && paddr == `OFS_SNAP_DOUBLE && w1;   // R24

  // Task triggers from software or shortcuts; start and stop ignored while disabled
  wire running   = (state == ST_RUN);
  wire start_go  = en & (wr_start | link_q[`LNK_SMP_START]);   // R10 R18
  wire stop_go   = en & running & (wr_stop | link_q[`LNK_SMP_STOP]
                  | link_q[`LNK_REP_STOP] | link_q[`LNK_DBL_STOP]); // R11
  wire snap_both = wr_both | link_q[`LNK_REP_BOTH];           // R18
  wire snap_mot  = snap_both | wr_motion | link_q[`LNK_REP_MOTION]; // R13
  wire snap_dbl  = snap_both | wr_double | link_q[`LNK_DBL_DOUBLE]; // R14

  // Sampling instant and the pair that is captured there
  wire        samp_tick = running & (rem == 32'h00000000);
  wire [1:0]  live_pair = {rt.phase_a, rt.phase_b};
  wire [1:0]  src_pair  = dbf ? filt_pair : live_pair;            // R23
  wire [1:0]  step      = gray_pos(src_pair) - gray_pos(prev_pair); // R20
  wire        is_up     = samp_tick && step == 2'h1;
  wire        is_down   = samp_tick && step == 2'h3;
  wire        is_dbl    = samp_tick && step == 2'h2;

  // Accumulator arithmetic; a clear and a new sample in one cycle combine
  wire [31:0] acc_base  = snap_mot ? 32'h00000000 : acc;
  wire [31:0] dbl_base  = snap_dbl ? 32'h00000000 : dbl;
  wire        acc_ovf   = (is_up && $signed(acc_base) == `ACC_MAX)
                       || (is_down && $signed(acc_base) == `ACC_MIN); // R16
  wire        dbl_ovf   = is_dbl && dbl_base == `DBL_MAX;             // R16
  wire [31:0] next_acc  = acc_ovf ? acc_base
                        : is_up ? acc_base + 32'h00000001
                        : is_down ? acc_base - 32'h00000001
                        : acc_base;                                   // R21
  wire [31:0] next_dbl  = (is_dbl && !dbl_ovf) ? dbl_base + 32'h00000001
                        : dbl_base;                                   // R20

  // Report boundary after the configured number of samples
  wire        rep_end   = samp_tick
                        && {1'b0, rep_seen} >= {2'b00, rep_cnt_cfg}; // R15
  wire        ev_report = rep_end && next_acc != 32'h00000000;       // R17
  wire        ev_double = rep_end && next_dbl != 32'h00000000;       // R17
  wire        ev_ovf    = acc_ovf | dbl_ovf;                         // R16
  wire [4:0]  ev_set    = {stop_go, ev_double, ev_ovf, ev_report,
                           samp_tick};                               // R11 R12
  wire [31:0] lead_cyc  = 32'(lead) * 32'(`CLK_MHZ);
  wire        led_on    = running & (dbf | rem <= lead_cyc);         // R22

  // Event flag clear strobes: a write of 0 to a flag address
  wire [4:0]  ev_clr = {4'h0, 1'b0} | {
    wr && paddr == `OFS_EV_HALT && !w1,
    wr && paddr == `OFS_EV_DOUBLE && !w1,
    wr && paddr == `OFS_EV_OVF && !w1,
    wr && paddr == `OFS_EV_REPORT && !w1,
    wr && paddr == `OFS_EV_SAMPLE && !w1};

  // Run state; disabling the decoder drops it straight to idle
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start_go) next_state = ST_RUN;       // R10
      ST_RUN:  if (stop_go || !en) next_state = ST_IDLE; // R11
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= ST_IDLE;
    else          state <= next_state;
  end

  // Configuration registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en          <= 1'b0;
      pol         <= 1'b0;
      interval    <= 4'h0;
      rep_cnt_cfg <= 4'h0;
      dbf         <= 1'b0;
      lead        <= 9'h000;
      links       <= 7'h00;
      irq_mask    <= 5'h00;
      sel_a       <= to_sel(`SEL_RESET);
      sel_b       <= to_sel(`SEL_RESET);
      sel_led     <= to_sel(`SEL_RESET);
    end else if (wr) begin
      unique case (paddr)
        `OFS_ENABLE:     en          <= w1;                 // R2
        `OFS_POLARITY:   pol         <= w1;
        `OFS_INTERVAL:   interval    <= pwdata[3:0];
        `OFS_REPORT_CNT: rep_cnt_cfg <= pwdata[3:0];        // R15
        `OFS_DEBOUNCE:   dbf         <= w1;                 // R19
        `OFS_LEAD:       lead        <= pwdata[8:0];        // R19
        `OFS_LINKS:      links       <= pwdata[6:0];        // R18
        `OFS_IRQ_SET:    irq_mask    <= irq_mask | pwdata[4:0];
        `OFS_IRQ_CLR:    irq_mask    <= irq_mask & ~pwdata[4:0];
        `OFS_SEL_A:      sel_a       <= to_sel(pwdata);     // R4
        `OFS_SEL_B:      sel_b       <= to_sel(pwdata);     // R4
        `OFS_SEL_LED:    sel_led     <= to_sel(pwdata);     // R4 R5
        default: ;
      endcase
    end
  end

  // Event flags: hardware set wins over a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flags <= 5'h00;
    else          flags <= ev_set | (flags & ~ev_clr); // R24
  end

  // Shortcuts turn this cycle's events into next cycle's tasks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_q <= 7'h00;
    end else begin
      link_q[`LNK_REP_BOTH]   <= links[`LNK_REP_BOTH] & ev_report;   // R18
      link_q[`LNK_SMP_STOP]   <= links[`LNK_SMP_STOP] & samp_tick;   // R18
      link_q[`LNK_REP_MOTION] <= links[`LNK_REP_MOTION] & ev_report; // R18
      link_q[`LNK_REP_STOP]   <= links[`LNK_REP_STOP] & ev_report;   // R18
      link_q[`LNK_DBL_DOUBLE] <= links[`LNK_DBL_DOUBLE] & ev_double; // R18
      link_q[`LNK_DBL_STOP]   <= links[`LNK_DBL_STOP] & ev_double;   // R18
      link_q[`LNK_SMP_START]  <= links[`LNK_SMP_START] & samp_tick;  // R18
    end
  end

  // Period countdown; sampling happens when it reaches zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem <= 32'h00000000;
    end else if (start_go && !running) begin
      rem <= period_cyc(interval) - 32'h00000001; // R10
    end else if (running) begin
      rem <= samp_tick ? period_cyc(interval) - 32'h00000001
                       : rem - 32'h00000001;
    end
  end

  // Capture, decode and accumulate at each sampling instant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_pair <= 2'h0;
      sample    <= 32'h00000000;
      acc       <= 32'h00000000;
      dbl       <= 32'h00000000;
      acc_snap  <= 32'h00000000;
      dbl_snap  <= 32'h00000000;
      rep_seen  <= 5'h00;
    end else begin
      if (start_go && !running) prev_pair <= src_pair;
      else if (samp_tick)       prev_pair <= src_pair;
      if (samp_tick) begin
        sample <= is_up ? 32'h00000001 : is_down ? 32'hFFFFFFFF
                : is_dbl ? 32'h00000002 : 32'h00000000; // R12 R20
      end
      acc <= next_acc;                    // R21
      dbl <= next_dbl;                    // R20
      if (snap_mot) acc_snap <= acc;      // R13
      if (snap_dbl) dbl_snap <= dbl;      // R14
      if (start_go && !running) rep_seen <= 5'h00;
      else if (rep_end)         rep_seen <= 5'h00;
      else if (samp_tick)       rep_seen <= rep_seen + 5'h01;
    end
  end

  // Debounce: 1 MHz samples must all agree over a whole period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt  <= 8'h00;
      last_pair <= 2'h0;
      filt_pair <= 2'h0;
      agree     <= 2'h3;
    end else if (running && dbf) begin
      tick_cnt <= (tick_cnt == 8'(`DBF_TICK_CYC - 1)) ? 8'h00
                : tick_cnt + 8'h01;
      if (tick_cnt == 8'h00) last_pair <= live_pair; // R23
      if (samp_tick) begin
        filt_pair <= (agree & last_pair) | (~agree & filt_pair); // R23
        agree     <= 2'h3;
      end else if (tick_cnt == 8'h00) begin
        agree <= agree & ~(live_pair ^ last_pair); // R23
      end
    end else begin
      tick_cnt  <= 8'h00;
      last_pair <= live_pair;
      filt_pair <= live_pair;
      agree     <= 2'h3;
    end
  end

  // Indicator level; it stays on throughout while debouncing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) led_level <= 1'b0;
    else          led_level <= pol ? led_on : ~led_on; // R22
  end

  // Read decode; write-only task addresses read as zero
  always_comb begin
    rd_word = 32'h00000000;
    rd_ok   = 1'b1;
    unique case (paddr)
      `OFS_START, `OFS_STOP, `OFS_SNAP_BOTH,
      `OFS_SNAP_MOTION, `OFS_SNAP_DOUBLE: rd_word = 32'h00000000;
      `OFS_EV_SAMPLE:  rd_word = {31'h0, flags[0]};
      `OFS_EV_REPORT:  rd_word = {31'h0, flags[1]};
      `OFS_EV_OVF:     rd_word = {31'h0, flags[2]};
      `OFS_EV_DOUBLE:  rd_word = {31'h0, flags[3]};
      `OFS_EV_HALT:    rd_word = {31'h0, flags[4]};
      `OFS_LINKS:      rd_word = {25'h0, links};
      `OFS_IRQ_SET, `OFS_IRQ_CLR: rd_word = {27'h0, irq_mask};
      `OFS_ENABLE:     rd_word = {31'h0, en};
      `OFS_POLARITY:   rd_word = {31'h0, pol};
      `OFS_INTERVAL:   rd_word = {28'h0, interval};
      `OFS_SAMPLE:     rd_word = sample;
      `OFS_REPORT_CNT: rd_word = {28'h0, rep_cnt_cfg};
      `OFS_ACC:        rd_word = acc;
      `OFS_ACC_SNAP:   rd_word = acc_snap;
      `OFS_SEL_LED:    rd_word = {sel_led[5], 26'h0, sel_led[4:0]};
      `OFS_SEL_A:      rd_word = {sel_a[5], 26'h0, sel_a[4:0]};
      `OFS_SEL_B:      rd_word = {sel_b[5], 26'h0, sel_b[4:0]};
      `OFS_DEBOUNCE:   rd_word = {31'h0, dbf};
      `OFS_LEAD:       rd_word = {23'h0, lead};
      `OFS_DBL:        rd_word = dbl;
      `OFS_DBL_SNAP:   rd_word = dbl_snap;
      default:         rd_ok   = 1'b0;
    endcase
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h00000000 : rd_word;
      pslverr <= ~rd_ok;
    end
  end

  assign pready = 1'b1;

  // Hand the pin selections to the router
  assign rt.enable    = en;      // R2 R6
  assign rt.sel_a     = sel_a;
  assign rt.sel_b     = sel_b;
  assign rt.sel_led   = sel_led;
  assign rt.led_level = led_level;

  pin_router u_router (
    .pclk         (pclk),
    .presetn      (presetn),
    .rt           (rt.router),
    .pad_in       (pad_in),
    .gpio_out_val (gpio_out_val),
    .gpio_out_en  (gpio_out_en),
    .pad_out      (pad_out),
    .pad_oe       (pad_oe),
    .gpio_read    (gpio_read)
  );

endmodule

// ---- tb/quad_encoder.sv ----
/*
  Incremental encoder model: one Gray step per up or down command, two per skip.
  Assumes move is a one-cycle command from the bench.
*/
`timescale 1ns/1ps
module quad_encoder (
  // Clock and step command: 1 up, 2 down, 3 skip two
  input  wire logic       pclk,
  input  wire logic [1:0] move,
  // Phase outputs
  output logic            phase_a,
  output logic            phase_b
);
  logic [1:0] pos = 2'h0;
  // A skip of two flips both phases at once, as a too fast wheel does
  always @(posedge pclk) begin
    case (move)
      2'h1: pos <= pos + 2'h1;
      2'h2: pos <= pos - 2'h1;
      2'h3: pos <= pos + 2'h2;
      default: pos <= pos;
    endcase
  end
  // Gray order 00, 01, 11, 10 counts up
  assign phase_a = pos[1];
  assign phase_b = pos[1] ^ pos[0];
endmodule

// ---- tb/quad_props.sv ----
/*
  Checker on the decoder's top ports: APB answers, pin ownership and
  the plain port path. Assumes the bind in testbench, zero-wait APB.
*/
`timescale 1ns/1ps
`include "quad_consts.svh"
module quad_props #(
  parameter int SAMPLE_BASE_CYC = 8
)(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pads
  input wire logic [31:0] pad_in,
  input wire logic [31:0] gpio_out_val,
  input wire logic [31:0] gpio_out_en,
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] gpio_read
);
  logic        en_q;
  logic [31:0] sa;
  logic [31:0] sl;
  logic [1:0]  up;
  wire         setup = psel && !penable;
  wire         wr_go = psel && penable && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadows of enable and selects; up masks the first edges after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      sa   <= `SEL_RESET;
      sl   <= `SEL_RESET;
      up   <= 2'h0;
    end else begin
      up <= (up == 2'h3) ? up : up + 2'h1;
      if (wr_go && paddr == `OFS_ENABLE) en_q <= pwdata[0];
      if (wr_go && paddr == `OFS_SEL_A) sa <= pwdata;
      if (wr_go && paddr == `OFS_SEL_LED) sl <= pwdata;
    end
  end
  unmapped_err_a: assert property (setup && paddr == 12'h7FC |=> pslverr)
    else $error("no error on unmapped address");
  enable_read_a: assert property (setup && !pwrite
    && paddr == `OFS_ENABLE |=> !pslverr && prdata[0] == en_q)
    else $error("enable readback");
  ready_high_a: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  prdata_hold_a: assert property (!setup |=> $stable(prdata)
    && $stable(pslverr)) else $error("read answer moved");
  sel_read_a: assert property (setup && !pwrite && paddr == `OFS_SEL_A
    |=> prdata[31] == sa[31] && prdata[4:0] == sa[4:0])
    else $error("select readback");
  phase_free_a: assert property (up == 2'h3 && en_q && $past(en_q)
    && !sa[31] |-> !pad_oe[sa[4:0]]) else $error("phase pin driven");
  led_drive_a: assert property (en_q && $past(en_q) && !sl[31]
    |-> pad_oe[sl[4:0]]) else $error("indicator pin not driven");
  gpio_pass_a: assert property (up == 2'h3 && !en_q && !$past(en_q)
    && $stable(gpio_out_val) && $stable(gpio_out_en)
    |-> pad_out == gpio_out_val && pad_oe == gpio_out_en)
    else $error("port path broken while disabled");
  read_live_a: assert property ((up == 2'h3) ##0 ($stable(pad_in))[*6]
    |-> gpio_read == pad_in) else $error("pad read not live");
  // Main scenarios reached
  cover property (en_q && !sa[31]);
  cover property (setup && paddr == `OFS_EV_OVF);
  cover property (wr_go && paddr == `OFS_START);
endmodule

// ---- tb/testbench.sv ----
/*
  Testbench: APB tasks and sequences against the decoder.
  Assumes encoder phases on pads 3 and 4, indicator on pad 5.
*/
`timescale 1ns/1ps
`include "quad_consts.svh"
module testbench;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        ph_a, ph_b;
  logic [1:0]  move;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pad_in, pad_out, pad_oe, gpio_read, d;
  logic [31:0] gpio_out_val, gpio_out_en;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [11:0] cfg_a [7] = '{`OFS_SEL_A, `OFS_SEL_B, `OFS_SEL_LED,
    `OFS_INTERVAL, `OFS_REPORT_CNT, `OFS_DEBOUNCE, `OFS_ENABLE};
  logic [31:0] cfg_d [7] = '{32'h3, 32'h4, 32'h5, 32'h0, 32'h0, 32'h0,
    32'h1};
  // Encoder on pads 3 and 4; other pads hold a fixed pattern
  assign pad_in = {27'h48D159E, ph_b, ph_a, 3'h5};
  quadrature_decoder #(.SAMPLE_BASE_CYC(8)) quadrature_decoder_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pad_in, .gpio_out_val, .gpio_out_en, .pad_out,
    .pad_oe, .gpio_read);
  quad_encoder quad_encoder_inst (.pclk, .move, .phase_a(ph_a),
    .phase_b(ph_b));
  always #2 pclk = ~pclk;
  // Hang guard: the run needs about 22000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer, held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hFFFFFFFF);
    xfer(1'b0, a, 32'h0);
    chk(d & m, exp);
  endtask
  // Spacing of 21 cycles lets several samples see each step
  task automatic step(input logic [1:0] k);
    move <= k;
    @(posedge pclk);
    move <= 2'h0;
    tick(20);
  endtask
  task automatic give_verdict();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    move = 2'h0;
    gpio_out_val = 32'hA5A50F0F;
    gpio_out_en = 32'hFFFF00FF;
    tick(3);
    presetn <= 1'b1;
    // Reset selects are disconnected; an unmapped place answers an error
    rc(`OFS_SEL_A, 32'h8000001F, 32'h8000001F);
    xfer(1'b0, 12'h7FC, 32'h0);
    chk({31'h0, e}, 32'h1);
    tick(8);
    chk(pad_out, gpio_out_val);
    chk(pad_oe, gpio_out_en);
    chk(gpio_read, pad_in);
    // Decoder pins made port inputs before enabling
    gpio_out_en <= 32'hFFFF00C7;
    for (int i = 0; i < 7; i++) wr(cfg_a[i], cfg_d[i]);
    rc(`OFS_SEL_B, 32'h4, 32'h8000001F);
    rc(`OFS_ENABLE, 32'h1);
    tick(4);
    chk(pad_oe & 32'h38, 32'h20);
    wr(`OFS_START, 32'h1);
    tick(20);
    repeat (5) step(2'h1);
    repeat (2) step(2'h2);
    step(2'h3);
    chk(gpio_read & 32'h18, pad_in & 32'h18);
    rc(`OFS_ACC, 32'h3);
    rc(`OFS_DBL, 32'h1);
    rc(`OFS_EV_SAMPLE, 32'h1);
    rc(`OFS_EV_REPORT, 32'h1);
    rc(`OFS_EV_DOUBLE, 32'h1);
    wr(`OFS_SNAP_MOTION, 32'h1);
    rc(`OFS_ACC_SNAP, 32'h3);
    rc(`OFS_DBL_SNAP, 32'h0);
    rc(`OFS_ACC, 32'h0);
    wr(`OFS_SNAP_DOUBLE, 32'h1);
    rc(`OFS_DBL_SNAP, 32'h1);
    rc(`OFS_ACC_SNAP, 32'h3);
    // A cleared flag stays clear while nothing accumulates
    wr(`OFS_EV_REPORT, 32'h0);
    tick(40);
    rc(`OFS_EV_REPORT, 32'h0);
    // Drive into the ceiling, then back off by one
    repeat (1024) step(2'h1);
    rc(`OFS_ACC, 32'h3FF);
    rc(`OFS_EV_OVF, 32'h1);
    step(2'h2);
    rc(`OFS_ACC, 32'h3FE);
    wr(`OFS_SNAP_BOTH, 32'h1);
    rc(`OFS_ACC_SNAP, 32'h3FE);
    rc(`OFS_ACC, 32'h0);
    wr(`OFS_STOP, 32'h1);
    tick(2);
    rc(`OFS_EV_HALT, 32'h1);
    step(2'h1);
    rc(`OFS_ACC, 32'h0);
    // Sample event chained to stop halts the decoder unaided
    wr(`OFS_LINKS, 32'h2);
    wr(`OFS_EV_HALT, 32'h0);
    rc(`OFS_EV_HALT, 32'h0);
    wr(`OFS_START, 32'h1);
    step(2'h1);
    rc(`OFS_EV_HALT, 32'h1);
    rc(`OFS_SAMPLE, 32'h1);
    chk(pad_out & 32'h20, 32'h20);
    wr(`OFS_ENABLE, 32'h0);
    tick(4);
    chk(pad_oe, gpio_out_en);
    chk(pad_out, gpio_out_val);
    give_verdict();
  end
endmodule
bind quadrature_decoder quad_props #(.SAMPLE_BASE_CYC(SAMPLE_BASE_CYC))
  quad_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .pad_in, .gpio_out_val, .gpio_out_en,
  .pad_out, .pad_oe, .gpio_read);
